// ---- src/osbc_defs.svh ----
// Offsets, field positions, reset values and counts of the clock and boot control block
`ifndef OSBC_DEFS_SVH
`define OSBC_DEFS_SVH

`define OSBC_IDX_CLKMD      6'h03
`define OSBC_IDX_CRYSTAL    6'h0B
`define OSBC_IDX_TRIM       6'h0C
`define OSBC_IDX_STATUS     6'h0D

`define OSBC_CLKMD_FAST_EN  4
`define OSBC_CLKMD_SLOW_EN  2
`define OSBC_CRYSTAL_EN     7
`define OSBC_CRYSTAL_DRV_HI 6
`define OSBC_CRYSTAL_DRV_LO 5

`define OSBC_CLKMD_RESET    8'hF4
`define OSBC_CRYSTAL_RESET  8'h00
`define OSBC_TRIM_RESET     8'h80

`define OSBC_CLKMD_DIV2     8'h34
`define OSBC_CLKMD_DIV4     8'h14
`define OSBC_CLKMD_DIV8     8'h3C
`define OSBC_CLKMD_DIV16    8'h1C
`define OSBC_CLKMD_DIV32    8'h7C
`define OSBC_CLKMD_SLOW     8'hE4

`define OSBC_SEL_DIV2       4'h2
`define OSBC_SEL_DIV4       4'h0
`define OSBC_SEL_DIV8       4'h3
`define OSBC_SEL_DIV16      4'h1
`define OSBC_SEL_DIV32      4'h7
`define OSBC_SEL_SLOW       4'hE
`define OSBC_SEL_CRYSTAL    4'hA

`define OSBC_BOOT_FAST_CYC  12'd47
`define OSBC_BOOT_NORM_CYC  12'd2945

`define OSBC_VEC_RESET      11'h001
`define OSBC_VEC_INT        11'h010

`endif

// ---- src/osbc_pkg.sv ----
// Types of the clock and boot control block
package osbc_pkg;

    typedef enum logic [2:0] {
        OSBC_CAL_DIV2,
        OSBC_CAL_DIV4,
        OSBC_CAL_DIV8,
        OSBC_CAL_DIV16,
        OSBC_CAL_DIV32,
        OSBC_CAL_SLOW,
        OSBC_CAL_OFF
    } osbc_cal_t;

    typedef enum logic [1:0] {
        OSBC_SRC_FAST,
        OSBC_SRC_SLOW,
        OSBC_SRC_CRYSTAL
    } osbc_src_t;

    typedef enum logic [1:0] {
        OSBC_BOOT_WAIT,
        OSBC_BOOT_APPLY,
        OSBC_BOOT_RUN
    } osbc_boot_t;

endpackage : osbc_pkg

// ---- src/osbc_boot_cnt.sv ----
// Boot delay counter advanced by slow RC oscillator edges
`include "osbc_defs.svh"

module osbc_boot_cnt #(
    parameter logic [11:0] FAST_CYCLES = `OSBC_BOOT_FAST_CYC,
    parameter logic [11:0] NORM_CYCLES = `OSBC_BOOT_NORM_CYC
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        slow_edge,
    input  wire logic        fast_boot,
    output logic      [11:0] cnt_q,
    output logic             done_q
);

    logic [11:0] target;

    assign target = fast_boot ? FAST_CYCLES : NORM_CYCLES;

    // Counts from power-on release; saturates so done stays until next reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 12'h000;
        end else if (slow_edge && cnt_q != target) begin
            cnt_q <= cnt_q + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == target);
        end
    end

endmodule : osbc_boot_cnt

// ---- src/osbc_top.sv ----
// Oscillator select, trim and power-on boot sequencing with an APB register port
//
// The register offsets and register access over APB were decided locally.
`include "osbc_defs.svh"

// Function
// - Crystal, fast RC and slow RC each have their own enable bit.
// - At boot completion both fast RC and slow RC oscillators run.
// - Boot delay is 47 slow RC cycles fast, 2945 normal.
// - After reset, fetch starts at 0x001; 0x000 is never the entry.
// - A taken interrupt vectors fetch to address 0x10.
// - Fast RC frequency is set by a trim register, normally to 16MHz.
// - Trim targets 14 to 18 MHz; fast RC dividers 2,4,8,16,32.
// - Clock mode 34h, 14h, 3Ch give fast RC /2, /4, /8.
// - Clock mode 1Ch gives fast RC /16, 7Ch gives /32.
// - Clock mode E4h selects undivided slow RC and stops fast RC.
// - With calibration off, clock mode and trim keep boot values.
// - After calibrating boot: watchdog off, slow RC on, port A bit5 input.
// - A clock mode write switches source and divider at once.
module osbc_top
    import osbc_pkg::*;
#(
    parameter osbc_cal_t   CAL_OPTION  = OSBC_CAL_DIV2,
    parameter logic        FAST_BOOT   = 1'b0,
    parameter logic [7:0]  CAL_TRIM    = 8'h80,
    parameter int          CAL_MHZ     = 16,
    parameter logic [11:0] BOOT_FAST   = `OSBC_BOOT_FAST_CYC,
    parameter logic [11:0] BOOT_NORM   = `OSBC_BOOT_NORM_CYC
) (
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SLOW_RC_CLK,
    input  wire logic        INT_TAKEN,
    output logic             CRYSTAL_OSC_EN,
    output logic [1:0]       CRYSTAL_DRIVE,
    output logic             FAST_RC_OSC_EN,
    output logic             SLOW_RC_OSC_EN,
    output logic [7:0]       FAST_RC_TRIM,
    output logic [1:0]       SYSCLK_SRC,
    output logic [2:0]       SYSCLK_DIV_LOG2,
    output logic             CORE_RST_N,
    output logic             FETCH_LOAD,
    output logic [10:0]      FETCH_ADDR,
    output logic             WDT_EN,
    output logic             PORT_A_BIT5_OE_N
);

    // Targets outside the trimmable band cannot be reached by the oscillator
    localparam logic CAL_MHZ_OK = (CAL_MHZ >= 14) && (CAL_MHZ <= 18);

    logic [7:0]  clkmd_q;
    logic [7:0]  clkmd_d;
    logic [7:0]  crystal_q;
    logic [7:0]  trim_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        sync1_q;
    logic        sync2_q;
    logic        sync3_q;
    logic        slow_edge;
    logic [11:0] boot_cnt;
    logic        boot_done;
    osbc_boot_t  boot_q;
    osbc_src_t   src_q;
    logic [2:0]  div_q;
    logic        core_rst_n_q;
    logic        fetch_load_q;
    logic [10:0] fetch_addr_q;
    logic        wdt_en_q;
    logic        pa5_oe_n_q;
    logic        apb_acc;
    logic        apb_commit;
    logic        apb_hit;
    logic        wr_clkmd;
    logic        wr_crystal;
    logic        wr_trim;
    logic        apply_cal;
    logic [31:0] rd_val;

    function automatic logic [7:0] cal_clkmd(input osbc_cal_t opt);
        unique case (opt)
            OSBC_CAL_DIV2:  cal_clkmd = `OSBC_CLKMD_DIV2;
            OSBC_CAL_DIV4:  cal_clkmd = `OSBC_CLKMD_DIV4;
            OSBC_CAL_DIV8:  cal_clkmd = `OSBC_CLKMD_DIV8;
            OSBC_CAL_DIV16: cal_clkmd = `OSBC_CLKMD_DIV16;
            OSBC_CAL_DIV32: cal_clkmd = `OSBC_CLKMD_DIV32;
            OSBC_CAL_SLOW:  cal_clkmd = `OSBC_CLKMD_SLOW;
            default:        cal_clkmd = `OSBC_CLKMD_RESET;
        endcase
    endfunction : cal_clkmd

    // Source select is bits 7:5 with bit 3; codes outside the known set fall to /64
    function automatic logic [4:0] decode_sel(input logic [7:0] mode);
        logic [3:0] key;
        key = {mode[7:5], mode[3]};
        case (key)
            `OSBC_SEL_DIV2:    decode_sel = {OSBC_SRC_FAST, 3'h1};
            `OSBC_SEL_DIV4:    decode_sel = {OSBC_SRC_FAST, 3'h2};
            `OSBC_SEL_DIV8:    decode_sel = {OSBC_SRC_FAST, 3'h3};
            `OSBC_SEL_DIV16:   decode_sel = {OSBC_SRC_FAST, 3'h4};
            `OSBC_SEL_DIV32:   decode_sel = {OSBC_SRC_FAST, 3'h5};
            `OSBC_SEL_SLOW:    decode_sel = {OSBC_SRC_SLOW, 3'h0};
            `OSBC_SEL_CRYSTAL: decode_sel = {OSBC_SRC_CRYSTAL, 3'h0};
            default:           decode_sel = {OSBC_SRC_FAST, 3'h6};
        endcase
    endfunction : decode_sel

    // Slow RC pin is asynchronous to the bus clock
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= SLOW_RC_CLK;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign slow_edge = sync2_q && !sync3_q;

    osbc_boot_cnt #(
        .FAST_CYCLES (BOOT_FAST),
        .NORM_CYCLES (BOOT_NORM)
    ) u_boot_cnt (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .slow_edge (slow_edge),
        .fast_boot (FAST_BOOT),
        .cnt_q     (boot_cnt),
        .done_q    (boot_done)
    );

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            boot_q <= OSBC_BOOT_WAIT;
        end else begin
            unique case (boot_q)
                OSBC_BOOT_WAIT:  if (boot_done) boot_q <= OSBC_BOOT_APPLY;
                OSBC_BOOT_APPLY: boot_q <= OSBC_BOOT_RUN;
                OSBC_BOOT_RUN:   boot_q <= OSBC_BOOT_RUN;
                default:         boot_q <= OSBC_BOOT_WAIT;
            endcase
        end
    end

    assign apply_cal = (boot_q == OSBC_BOOT_APPLY) && (CAL_OPTION != OSBC_CAL_OFF);

    // APB: one wait state, answer registered in the first access cycle
    assign apb_acc    = PSEL && PENABLE;
    assign apb_commit = apb_acc && pready_q;
    assign apb_hit    = (PADDR[7:2] == `OSBC_IDX_CLKMD) || (PADDR[7:2] == `OSBC_IDX_CRYSTAL)
                     || (PADDR[7:2] == `OSBC_IDX_TRIM) || (PADDR[7:2] == `OSBC_IDX_STATUS);
    assign wr_clkmd   = apb_commit && PWRITE && (PADDR[7:2] == `OSBC_IDX_CLKMD);
    assign wr_crystal = apb_commit && PWRITE && (PADDR[7:2] == `OSBC_IDX_CRYSTAL);
    assign wr_trim    = apb_commit && PWRITE && (PADDR[7:2] == `OSBC_IDX_TRIM);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (PADDR[7:2] == `OSBC_IDX_CLKMD) begin
            rd_val[7:0] = clkmd_q;
        end else if (PADDR[7:2] == `OSBC_IDX_CRYSTAL) begin
            rd_val[7:0] = crystal_q;
        end else if (PADDR[7:2] == `OSBC_IDX_TRIM) begin
            rd_val[7:0] = trim_q;
        end else if (PADDR[7:2] == `OSBC_IDX_STATUS) begin
            rd_val[7:0] = {CAL_MHZ_OK, FAST_BOOT, src_q, div_q, core_rst_n_q};
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else if (apb_acc && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= !apb_hit || (PWRITE && PADDR[7:2] == `OSBC_IDX_STATUS);
            prdata_q  <= PWRITE ? 32'h0000_0000 : rd_val;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end
    end

    // Calibration load happens while the core is still held; a bus write in the same cycle is dropped in its favour
    always_comb begin
        clkmd_d = clkmd_q;
        if (apply_cal) begin
            clkmd_d = cal_clkmd(CAL_OPTION);
        end else if (wr_clkmd) begin
            clkmd_d = PWDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            clkmd_q <= `OSBC_CLKMD_RESET;
        end else begin
            clkmd_q <= clkmd_d;
        end
    end

    // Source and divider follow the new mode on the same edge as the write
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            src_q <= OSBC_SRC_SLOW;
            div_q <= 3'h0;
        end else begin
            {src_q, div_q} <= decode_sel(clkmd_d);
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            crystal_q <= `OSBC_CRYSTAL_RESET;
        end else if (wr_crystal) begin
            crystal_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            trim_q <= `OSBC_TRIM_RESET;
        end else if (apply_cal) begin
            trim_q <= CAL_TRIM;
        end else if (wr_trim) begin
            trim_q <= PWDATA[7:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wdt_en_q   <= 1'b1;
            pa5_oe_n_q <= 1'b1;
        end else if (apply_cal) begin
            wdt_en_q   <= 1'b0;
            pa5_oe_n_q <= 1'b1;
        end
    end

    // Core held until boot completes; entry point skips the reserved word
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            core_rst_n_q <= 1'b0;
            fetch_load_q <= 1'b0;
            fetch_addr_q <= `OSBC_VEC_RESET;
        end else if (boot_q == OSBC_BOOT_APPLY) begin
            core_rst_n_q <= 1'b1;
            fetch_load_q <= 1'b1;
            fetch_addr_q <= `OSBC_VEC_RESET;
        end else if (core_rst_n_q && INT_TAKEN) begin
            fetch_load_q <= 1'b1;
            fetch_addr_q <= `OSBC_VEC_INT;
        end else begin
            fetch_load_q <= 1'b0;
        end
    end

    assign PRDATA           = prdata_q;
    assign PREADY           = pready_q;
    assign PSLVERR          = pslverr_q;
    assign CRYSTAL_OSC_EN   = crystal_q[`OSBC_CRYSTAL_EN];
    assign CRYSTAL_DRIVE    = crystal_q[`OSBC_CRYSTAL_DRV_HI:`OSBC_CRYSTAL_DRV_LO];
    assign FAST_RC_OSC_EN   = clkmd_q[`OSBC_CLKMD_FAST_EN];
    assign SLOW_RC_OSC_EN   = clkmd_q[`OSBC_CLKMD_SLOW_EN];
    assign FAST_RC_TRIM     = trim_q;
    assign SYSCLK_SRC       = src_q;
    assign SYSCLK_DIV_LOG2  = div_q;
    assign CORE_RST_N       = core_rst_n_q;
    assign FETCH_LOAD       = fetch_load_q;
    assign FETCH_ADDR       = fetch_addr_q;
    assign WDT_EN           = wdt_en_q;
    assign PORT_A_BIT5_OE_N = pa5_oe_n_q;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);

    sequence clkmd_write_s(logic [7:0] v);
        wr_clkmd && !apply_cal && PWDATA[7:0] == v;
    endsequence

    sequence boot_release_s;
        boot_q == OSBC_BOOT_WAIT ##1 boot_q == OSBC_BOOT_APPLY;
    endsequence

    osc_enables_a: assert property (
        wr_clkmd && !apply_cal |=> FAST_RC_OSC_EN == $past(PWDATA[4])
            && SLOW_RC_OSC_EN == $past(PWDATA[2]))
        else $error("oscillator enable bits do not follow the mode write");

    crystal_enable_a: assert property (
        wr_crystal |=> CRYSTAL_OSC_EN == $past(PWDATA[7]))
        else $error("crystal enable does not follow its write");

    boot_both_rc_a: assert property (
        boot_q == OSBC_BOOT_WAIT && boot_done |-> clkmd_q[4] && clkmd_q[2])
        else $error("fast or slow RC stopped at boot completion");

    boot_delay_a: assert property (
        $rose(CORE_RST_N) |-> boot_cnt == (FAST_BOOT ? BOOT_FAST : BOOT_NORM))
        else $error("core released before the boot delay expired");

    reset_vector_a: assert property (
        boot_release_s |=> CORE_RST_N && FETCH_LOAD && FETCH_ADDR == `OSBC_VEC_RESET)
        else $error("first fetch is not at the reset entry");

    int_vector_a: assert property (
        CORE_RST_N && INT_TAKEN |=> FETCH_LOAD && FETCH_ADDR == `OSBC_VEC_INT)
        else $error("interrupt did not vector to the entry address");

    trim_apply_a: assert property (
        apply_cal |=> FAST_RC_TRIM == CAL_TRIM)
        else $error("trim value not loaded by calibration");

    div_decode_a: assert property (
        clkmd_write_s(`OSBC_CLKMD_DIV2) |=> SYSCLK_SRC == OSBC_SRC_FAST
            && SYSCLK_DIV_LOG2 == 3'h1 ##1 FAST_RC_OSC_EN)
        else $error("mode 34h did not give fast RC divided by two");

    div32_decode_a: assert property (
        clkmd_write_s(`OSBC_CLKMD_DIV32) |=> SYSCLK_DIV_LOG2 == 3'h5)
        else $error("mode 7Ch did not give divide by 32");

    slow_decode_a: assert property (
        clkmd_write_s(`OSBC_CLKMD_SLOW) |=> SYSCLK_SRC == OSBC_SRC_SLOW
            && !FAST_RC_OSC_EN && SYSCLK_DIV_LOG2 == 3'h0)
        else $error("mode E4h did not select undivided slow RC");

    cal_off_a: assert property (
        boot_q == OSBC_BOOT_APPLY && CAL_OPTION == OSBC_CAL_OFF
            |=> $stable(clkmd_q) && $stable(trim_q) && WDT_EN)
        else $error("calibration off changed boot values");

    after_cal_a: assert property (
        apply_cal |=> !WDT_EN && SLOW_RC_OSC_EN && PORT_A_BIT5_OE_N)
        else $error("calibrated boot state is wrong");

endmodule : osbc_top

// ---- sim/osbc_top_tb.sv ----
// Self-checking bench of the clock select and boot control block
`include "osbc_defs.svh"

module osbc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [7:0] CAL_TRIM_V = 8'h5A;
    localparam logic [7:0] A_CLKMD    = {`OSBC_IDX_CLKMD, 2'b00};
    localparam logic [7:0] A_XTAL     = {`OSBC_IDX_CRYSTAL, 2'b00};
    localparam logic [7:0] A_TRIM     = {`OSBC_IDX_TRIM, 2'b00};
    localparam logic [7:0] A_STAT     = {`OSBC_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_NONE     = 8'h00;

    logic        SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, SLOW_RC_CLK, INT_TAKEN;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic        PREADY, PSLVERR, CRYSTAL_OSC_EN, FAST_RC_OSC_EN, SLOW_RC_OSC_EN;
    logic [1:0]  CRYSTAL_DRIVE, SYSCLK_SRC;
    logic [7:0]  FAST_RC_TRIM;
    logic [2:0]  SYSCLK_DIV_LOG2;
    logic        CORE_RST_N, FETCH_LOAD, WDT_EN, PORT_A_BIT5_OE_N;
    logic [10:0] FETCH_ADDR;
    logic        nc_rst_n, nc_wdt;
    logic [1:0]  nc_src;
    logic [2:0]  nc_div;
    logic [7:0]  nc_trim;
    int          num_errors, n_checks, n_slow;
    logic        slow_run;
    logic [1:0]  sdiv;
    logic [7:0]  codes [7] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hF4, 8'hE4};
    logic [2:0]  divs  [7] = '{3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd0, 3'd0};

    // Short boot counts keep the run brief; expectations use the same 5
    osbc_top #(.FAST_BOOT(1'b1), .CAL_TRIM(CAL_TRIM_V), .BOOT_FAST(12'd5),
               .BOOT_NORM(12'd9)) i_dut (
        .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .SLOW_RC_CLK(SLOW_RC_CLK),
        .INT_TAKEN(INT_TAKEN), .CRYSTAL_OSC_EN(CRYSTAL_OSC_EN),
        .CRYSTAL_DRIVE(CRYSTAL_DRIVE), .FAST_RC_OSC_EN(FAST_RC_OSC_EN),
        .SLOW_RC_OSC_EN(SLOW_RC_OSC_EN), .FAST_RC_TRIM(FAST_RC_TRIM),
        .SYSCLK_SRC(SYSCLK_SRC), .SYSCLK_DIV_LOG2(SYSCLK_DIV_LOG2),
        .CORE_RST_N(CORE_RST_N), .FETCH_LOAD(FETCH_LOAD), .FETCH_ADDR(FETCH_ADDR),
        .WDT_EN(WDT_EN), .PORT_A_BIT5_OE_N(PORT_A_BIT5_OE_N)
    );

    // Same bus and pins, calibration left out: boot values must survive
    osbc_top #(.CAL_OPTION(osbc_pkg::OSBC_CAL_OFF), .FAST_BOOT(1'b1), .CAL_TRIM(CAL_TRIM_V),
               .BOOT_FAST(12'd5), .BOOT_NORM(12'd9)) i_dut_nocal (
        .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(),
        .PREADY(), .PSLVERR(), .SLOW_RC_CLK(SLOW_RC_CLK),
        .INT_TAKEN(INT_TAKEN), .CRYSTAL_OSC_EN(), .CRYSTAL_DRIVE(),
        .FAST_RC_OSC_EN(), .SLOW_RC_OSC_EN(), .FAST_RC_TRIM(nc_trim),
        .SYSCLK_SRC(nc_src), .SYSCLK_DIV_LOG2(nc_div), .CORE_RST_N(nc_rst_n),
        .FETCH_LOAD(), .FETCH_ADDR(), .WDT_EN(nc_wdt), .PORT_A_BIT5_OE_N()
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end

    // Slow oscillator at one eighth of the system clock, counted at each rise
    always @(posedge SYS_CLK) begin
        if (slow_run) begin
            if (sdiv == 2'd3) begin
                SLOW_RC_CLK <= ~SLOW_RC_CLK;
                if (!SLOW_RC_CLK) begin
                    n_slow <= n_slow + 1;
                end
            end
            sdiv <= sdiv + 2'd1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic conclude;
        $display("Checks made %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge SYS_CLK);
        PSEL   <= 1'b1;
        PWRITE <= wr;
        PADDR  <= a;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge SYS_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            num_errors++;
            $display("MISMATCH at %0t: bus answer never came", $time);
            conclude();
        end
    endtask : apb

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h0, d}, rd, err);
        chk({31'h0, err}, {31'h0, exp_err}, "write error flag");
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        chk(rd, {24'h0, exp}, "read data");
        chk({31'h0, err}, {31'h0, exp_err}, "read error flag");
    endtask : rd_chk

    // Address must stay at reset entry unless a load really happened
    task automatic pulse_int(input logic exp);
        @(posedge SYS_CLK);
        INT_TAKEN <= 1'b1;
        @(posedge SYS_CLK);
        INT_TAKEN <= 1'b0;
        @(negedge SYS_CLK);
        chk(FETCH_LOAD, exp, "fetch load on interrupt");
        chk(FETCH_ADDR, exp ? 11'h010 : 11'h001, "fetch address");
        @(negedge SYS_CLK);
        chk(FETCH_LOAD, 1'b0, "fetch load one cycle");
    endtask : pulse_int

    initial begin
        int i;
        int n;
        ARST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00;
        PWDATA = 32'h0; SLOW_RC_CLK = 1'b0; INT_TAKEN = 1'b0; slow_run = 1'b0;
        sdiv = 2'd0; n_slow = 0; num_errors = 0; n_checks = 0;
        repeat (6) @(posedge SYS_CLK);
        ARST_N <= 1'b1;
        @(negedge SYS_CLK);
        chk(CORE_RST_N, 1'b0, "core held in reset");
        chk(FETCH_ADDR, 11'h001, "reset entry");
        chk(PORT_A_BIT5_OE_N, 1'b1, "port bit input");
        chk({FAST_RC_OSC_EN, SLOW_RC_OSC_EN}, 2'b11, "osc enables");
        rd_chk(A_CLKMD, `OSBC_CLKMD_RESET, 1'b0);
        rd_chk(A_TRIM, `OSBC_TRIM_RESET, 1'b0);
        rd_chk(A_XTAL, `OSBC_CRYSTAL_RESET, 1'b0);
        pulse_int(1'b0);
        $display("test reset done");

        @(posedge SYS_CLK);
        slow_run <= 1'b1;
        for (n = 0; n < 200 && CORE_RST_N !== 1'b1; n++) @(negedge SYS_CLK);
        if (CORE_RST_N !== 1'b1) begin
            num_errors++;
            $display("MISMATCH at %0t: core never left reset", $time);
            conclude();
        end
        chk({nc_rst_n, nc_wdt, nc_src, nc_div, nc_trim},
            {1'b1, 1'b1, 2'd1, 3'd0, `OSBC_TRIM_RESET}, "no calibration");
        chk(n_slow, 5, "slow edges before release");
        chk(CORE_RST_N, 1'b1, "core released");
        chk(FETCH_LOAD, 1'b1, "first fetch");
        chk(FETCH_ADDR, 11'h001, "first fetch address");
        chk({SYSCLK_SRC, SYSCLK_DIV_LOG2}, 5'b00001, "boot clock");
        chk({FAST_RC_OSC_EN, SLOW_RC_OSC_EN}, 2'b11, "both rc run");
        chk({WDT_EN, PORT_A_BIT5_OE_N}, 2'b01, "watchdog and port");
        chk(FAST_RC_TRIM, CAL_TRIM_V, "calibrated trim");
        @(negedge SYS_CLK);
        chk(FETCH_LOAD, 1'b0, "first fetch one cycle");
        rd_chk(A_CLKMD, `OSBC_CLKMD_DIV2, 1'b0);
        rd_chk(A_TRIM, CAL_TRIM_V, 1'b0);
        rd_chk(A_STAT, 8'hC3, 1'b0);
        $display("test boot done");

        pulse_int(1'b1);
        pulse_int(1'b1);
        $display("test interrupt done");

        // Fast source is left on in the write that moves to slow, stopped later
        for (i = 0; i < 7; i++) begin
            wr_reg(A_CLKMD, codes[i], 1'b0);
            @(negedge SYS_CLK);
            chk(SYSCLK_SRC, (i < 5) ? 2'd0 : 2'd1, "clock source");
            chk(SYSCLK_DIV_LOG2, divs[i], "divider");
            chk(FAST_RC_OSC_EN, codes[i][4], "fast enable");
            chk(SLOW_RC_OSC_EN, codes[i][2], "slow enable");
            rd_chk(A_CLKMD, codes[i], 1'b0);
        end
        $display("test clock modes done");

        wr_reg(A_XTAL, 8'hE0, 1'b0);
        @(negedge SYS_CLK);
        chk({CRYSTAL_OSC_EN, CRYSTAL_DRIVE}, 3'b111, "crystal control");
        wr_reg(A_CLKMD, 8'hA4, 1'b0);
        @(negedge SYS_CLK);
        chk(SYSCLK_SRC, 2'd2, "crystal source");
        wr_reg(A_TRIM, 8'hC3, 1'b0);
        @(negedge SYS_CLK);
        chk(FAST_RC_TRIM, 8'hC3, "trim output");
        rd_chk(A_TRIM, 8'hC3, 1'b0);
        $display("test crystal and trim done");

        rd_chk(A_NONE, 8'h00, 1'b1);
        wr_reg(A_NONE, 8'h55, 1'b1);
        wr_reg(A_STAT, 8'hFF, 1'b1);
        rd_chk(A_CLKMD, 8'hA4, 1'b0);
        $display("test refusals done");
        conclude();
    end
endmodule : osbc_top_tb
